// ---- rtl/crf_pkg.sv ----
// constants and types for the core register file
package crf_pkg;
  localparam int unsigned GP_COUNT  = 20;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned GP_IDX_W  = 5;
  localparam int unsigned ICS_W     = 20;
  localparam int unsigned SPR_SEL_W = 4;

  // special register selectors used by the input/output register instructions
  localparam logic [3:0] SEL_STACK_POINTER   = 4'h0;
  localparam logic [3:0] SEL_SYSTEM_STATUS   = 4'h1;
  localparam logic [3:0] SEL_UART_RX         = 4'h2;
  localparam logic [3:0] SEL_UART_TX         = 4'h3;
  localparam logic [3:0] SEL_PENDING_INT     = 4'h4;
  localparam logic [3:0] SEL_FAULT_FLAGS     = 4'h5;
  localparam logic [3:0] SEL_INT_MASK        = 4'h6;
  localparam logic [3:0] SEL_DISCRETE_OUT    = 4'h7;
  localparam logic [3:0] SEL_INSTR_COUNTER   = 4'h8;
  localparam logic [3:0] SEL_INSTR_CNT_SAVE  = 4'h9;
  localparam logic [3:0] SEL_CUR_INSTR       = 4'ha;
  localparam logic [3:0] SEL_FINE_TIMER      = 4'hb;
  localparam logic [3:0] SEL_COARSE_TIMER    = 4'hc;
  localparam logic [3:0] SEL_ACC_HIGH        = 4'hd;
  localparam logic [3:0] SEL_ACC_LOW         = 4'he;

  // power-up values; undefined bits are given zero here
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam logic [7:0]  RST_UART_LOW = 8'h00;
  localparam logic [7:0]  RST_DISC_LOW = 8'hff;
  localparam logic [19:0] RST_ICS      = 20'h00000;

  typedef enum logic [1:0] {
    CRF_ACC_NONE = 2'h0,
    CRF_ACC_MUL  = 2'h1,
    CRF_ACC_DIV  = 2'h2
  } crf_acc_op_t;
endpackage : crf_pkg

// ---- rtl/crf_core_register_file.sv ----
// register file of the 16-bit controller core
module crf_core_register_file
  import crf_pkg::*;
#(
  parameter int unsigned GpCount = crf_pkg::GP_COUNT
) (
  input  wire logic                          clk,           // 50 MHz clock
  input  wire logic                          arst_n,        // async reset, low
  input  wire logic [crf_pkg::GP_IDX_W-1:0]  rdAddrA,       // read port a index
  output logic      [crf_pkg::DATA_W-1:0]    rdDataA,       // read port a word
  input  wire logic [crf_pkg::GP_IDX_W-1:0]  rdAddrB,       // read port b index
  output logic      [crf_pkg::DATA_W-1:0]    rdDataB,       // read port b word
  output logic      [31:0]                   rdPairA,       // pair at rdAddrA
  input  wire logic                          wrEn,          // single word write
  input  wire logic [crf_pkg::GP_IDX_W-1:0]  wrAddr,        // write index
  input  wire logic [crf_pkg::DATA_W-1:0]    wrData,        // write word
  input  wire logic                          wrPairEn,      // pair write
  input  wire logic [31:0]                   wrPairData,    // pair data
  input  wire crf_pkg::crf_acc_op_t          accOp,         // multiply/divide result
  input  wire logic [31:0]                   accData,       // accumulator value
  input  wire logic                          stackPush,     // push request
  input  wire logic                          stackPop,      // pop request
  output logic      [crf_pkg::DATA_W-1:0]    stackAddr,     // data address for stack
  input  wire logic                          outRegEn,      // output-register instr
  input  wire logic                          inRegEn,       // input-register instr
  input  wire logic [crf_pkg::SPR_SEL_W-1:0] sprSel,        // special register select
  input  wire logic [crf_pkg::DATA_W-1:0]    sprWrData,     // value to write
  output logic      [crf_pkg::DATA_W-1:0]    sprRdData,     // value read (registered)
  output logic                               sprRdValid,    // read answer strobe
  input  wire logic [crf_pkg::DATA_W-1:0]    statusIn,      // live status word
  input  wire logic [crf_pkg::DATA_W-1:0]    uartRxIn,      // received word
  input  wire logic                          uartRxLoad,    // receive word arrives
  input  wire logic [crf_pkg::DATA_W-1:0]    instrIn,       // fetched instruction
  input  wire logic                          instrLoad,     // instruction latched
  output logic      [crf_pkg::DATA_W-1:0]    uartTxOut,     // transmit buffer
  output logic      [7:0]                    discreteOut,   // discrete output bus
  output logic      [crf_pkg::DATA_W-1:0]    instrCount,    // instruction counter
  output logic      [crf_pkg::DATA_W-1:0]    intMaskOut,    // interrupt mask
  output logic      [crf_pkg::DATA_W-1:0]    pendingOut,    // pending interrupts
  output logic      [crf_pkg::DATA_W-1:0]    faultOut,      // fault flags
  output logic      [crf_pkg::DATA_W-1:0]    fineTimerOut,  // fine timer
  output logic      [crf_pkg::DATA_W-1:0]    coarseTimerOut // coarse timer
);
  import crf_pkg::*;

  // ****************************************
  // general registers
  // ****************************************
  logic [DATA_W-1:0] gpReg_r [GpCount];
  logic [GP_IDX_W-1:0] pairHiIdx;
  logic [GP_IDX_W-1:0] pairLoIdx;
  logic [GP_IDX_W-1:0] rdPairHi;
  logic [GP_IDX_W-1:0] rdPairLo;

  // pairs always start on the even register
  assign pairHiIdx = {wrAddr[GP_IDX_W-1:1], 1'b0};
  assign pairLoIdx = {wrAddr[GP_IDX_W-1:1], 1'b1};
  assign rdPairHi  = {rdAddrA[GP_IDX_W-1:1], 1'b0};
  assign rdPairLo  = {rdAddrA[GP_IDX_W-1:1], 1'b1};

  genvar g;
  generate
    for (g = 0; g < GpCount; g++) begin : gen_gp
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          gpReg_r[g] <= RST_ZERO;
        end else if (wrPairEn && pairHiIdx == GP_IDX_W'(g)) begin
          gpReg_r[g] <= wrPairData[31:16];
        end else if (wrPairEn && pairLoIdx == GP_IDX_W'(g)) begin
          gpReg_r[g] <= wrPairData[15:0];
        end else if (wrEn && wrAddr == GP_IDX_W'(g)) begin
          gpReg_r[g] <= wrData;
        end
      end
    end
  endgenerate

  // out-of-range indices read zero
  always_comb begin
    rdDataA = (rdAddrA < GP_IDX_W'(GpCount)) ? gpReg_r[rdAddrA] : RST_ZERO;
    rdDataB = (rdAddrB < GP_IDX_W'(GpCount)) ? gpReg_r[rdAddrB] : RST_ZERO;
    rdPairA = (rdPairLo < GP_IDX_W'(GpCount)) ?
              {gpReg_r[rdPairHi], gpReg_r[rdPairLo]} : 32'h00000000;
  end

  // ****************************************
  // accumulator
  // ****************************************
  logic [31:0] acc_r;

  // never a general source; only reachable through the input instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= 32'h00000000;
    end else if (accOp != CRF_ACC_NONE) begin
      acc_r <= accData;
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  logic [DATA_W-1:0] stackPointer_r;

  // bit 15 is the msb of the packed vector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stackPointer_r <= RST_ZERO;
    end else if (outRegEn && sprSel == SEL_STACK_POINTER) begin
      stackPointer_r <= sprWrData;
    end else if (stackPop) begin
      stackPointer_r <= stackPointer_r + 16'h0001;
    end else if (stackPush) begin
      stackPointer_r <= stackPointer_r - 16'h0001;
    end
  end

  // pop addresses the incremented value in the same cycle
  assign stackAddr = stackPop ? stackPointer_r + 16'h0001 : stackPointer_r;

  // ****************************************
  // special registers
  // ****************************************
  logic [DATA_W-1:0] uartRx_r, uartTx_r, pending_r, fault_r, intMask_r, discrete_r;
  logic [DATA_W-1:0] instrCount_r, curInstr_r, fineTimer_r, coarseTimer_r;
  logic [ICS_W-1:0]  instrCountSave_r;
  logic              wrSel;

  assign wrSel = outRegEn;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_r     <= RST_ZERO;
      fault_r       <= RST_ZERO;
      instrCount_r  <= RST_ZERO;
      fineTimer_r   <= RST_ZERO;
      coarseTimer_r <= RST_ZERO;
    end else if (wrSel) begin
      if (sprSel == SEL_PENDING_INT)   pending_r     <= sprWrData;
      if (sprSel == SEL_FAULT_FLAGS)   fault_r       <= sprWrData;
      if (sprSel == SEL_INSTR_COUNTER) instrCount_r  <= sprWrData;
      if (sprSel == SEL_FINE_TIMER)    fineTimer_r   <= sprWrData;
      if (sprSel == SEL_COARSE_TIMER)  coarseTimer_r <= sprWrData;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      curInstr_r <= RST_ZERO;
    end else if (instrLoad) begin
      curInstr_r <= instrIn;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uartRx_r <= {8'h00, RST_UART_LOW};
    end else if (uartRxLoad) begin
      uartRx_r <= uartRxIn;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uartTx_r   <= {8'h00, RST_UART_LOW};
      discrete_r <= {8'h00, RST_DISC_LOW};
    end else if (wrSel) begin
      if (sprSel == SEL_UART_TX)      uartTx_r   <= sprWrData;
      if (sprSel == SEL_DISCRETE_OUT) discrete_r <= sprWrData;
    end
  end

  // no defined power-up contents; zero is simply a safe choice
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intMask_r        <= RST_ZERO;
      instrCountSave_r <= RST_ICS;
    end else if (wrSel) begin
      if (sprSel == SEL_INT_MASK)       intMask_r        <= sprWrData;
      if (sprSel == SEL_INSTR_CNT_SAVE) instrCountSave_r <= {4'h0, sprWrData};
    end
  end

  // ****************************************
  // input-register read path
  // ****************************************
  logic [DATA_W-1:0] sprMux;

  always_comb begin
    sprMux = RST_ZERO;
    unique case (sprSel)
      SEL_STACK_POINTER:  sprMux = stackPointer_r;
      SEL_SYSTEM_STATUS:  sprMux = statusIn;
      SEL_UART_RX:        sprMux = uartRx_r;
      SEL_PENDING_INT:    sprMux = pending_r;
      SEL_FAULT_FLAGS:    sprMux = fault_r;
      SEL_INT_MASK:       sprMux = intMask_r;
      SEL_DISCRETE_OUT:   sprMux = discrete_r;
      SEL_INSTR_COUNTER:  sprMux = instrCount_r;
      SEL_INSTR_CNT_SAVE: sprMux = instrCountSave_r[15:0];
      SEL_CUR_INSTR:      sprMux = curInstr_r;
      SEL_FINE_TIMER:     sprMux = fineTimer_r;
      SEL_COARSE_TIMER:   sprMux = coarseTimer_r;
      SEL_ACC_HIGH:       sprMux = acc_r[31:16];
      SEL_ACC_LOW:        sprMux = acc_r[15:0];
      default:            sprMux = RST_ZERO;                 // transmit buffer is write-only
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sprRdData  <= RST_ZERO;
      sprRdValid <= 1'b0;
    end else begin
      sprRdValid <= inRegEn;
      if (inRegEn) sprRdData <= sprMux;
    end
  end

  assign uartTxOut      = uartTx_r;
  assign discreteOut    = discrete_r[7:0];
  assign instrCount     = instrCount_r;
  assign intMaskOut     = intMask_r;
  assign pendingOut     = pending_r;
  assign faultOut       = fault_r;
  assign fineTimerOut   = fineTimer_r;
  assign coarseTimerOut = coarseTimer_r;

  // ****************************************
  // assertions
  // ****************************************
  a_pair_order: assert property (@(posedge clk) disable iff (!arst_n)
    wrPairEn && pairLoIdx < 5'(GpCount) |=>
      gpReg_r[$past(pairHiIdx)] == $past(wrPairData[31:16]) &&
      gpReg_r[$past(pairLoIdx)] == $past(wrPairData[15:0]))
    else $error("pair halves misplaced");
  a_single_write: assert property (@(posedge clk) disable iff (!arst_n)
    wrEn && !wrPairEn && wrAddr < 5'(GpCount) |=> gpReg_r[$past(wrAddr)] == $past(wrData))
    else $error("single word write lost");
  a_acc_load: assert property (@(posedge clk) disable iff (!arst_n)
    accOp != CRF_ACC_NONE |=> acc_r == $past(accData))
    else $error("accumulator not loaded");
  a_acc_hold: assert property (@(posedge clk) disable iff (!arst_n)
    accOp == CRF_ACC_NONE |=> $stable(acc_r))
    else $error("accumulator changed without result");
  a_pop_addr: assert property (@(posedge clk) disable iff (!arst_n)
    stackPop && !outRegEn |-> stackAddr == stackPointer_r + 16'h0001 ##1
      stackPointer_r == $past(stackAddr))
    else $error("pop not pre-incremented");
  a_push_addr: assert property (@(posedge clk) disable iff (!arst_n)
    stackPush && !stackPop && !outRegEn |-> stackAddr == stackPointer_r ##1
      stackPointer_r == $past(stackAddr) - 16'h0001)
    else $error("push not post-decremented");
  a_sp_read: assert property (@(posedge clk) disable iff (!arst_n)
    inRegEn && sprSel == SEL_STACK_POINTER |=> sprRdValid && sprRdData == $past(stackPointer_r))
    else $error("stack pointer read wrong");
  a_status_read: assert property (@(posedge clk) disable iff (!arst_n)
    inRegEn && sprSel == SEL_SYSTEM_STATUS |=> sprRdData == $past(statusIn))
    else $error("status read wrong");
  a_timer_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_FINE_TIMER |=> fineTimerOut == $past(sprWrData))
    else $error("timer write lost");
  // halves are held against the single-word port, not against the pair mux
  a_pair_even_half: assert property (@(posedge clk) disable iff (!arst_n)
    !rdAddrA[0] && rdAddrA < 5'(GpCount) |-> rdPairA[31:16] == rdDataA)
    else $error("pair high half not from even register");
  a_pair_odd_half: assert property (@(posedge clk) disable iff (!arst_n)
    rdAddrA[0] && rdAddrA < 5'(GpCount) |-> rdPairA[15:0] == rdDataA)
    else $error("pair low half not from odd register");
  a_oob_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    rdAddrA >= 5'(GpCount) |-> rdDataA == RST_ZERO)
    else $error("port a read past the file");
  a_oob_read_b: assert property (@(posedge clk) disable iff (!arst_n)
    rdAddrB >= 5'(GpCount) |-> rdDataB == RST_ZERO)
    else $error("port b read past the file");
  a_acc_read_high: assert property (@(posedge clk) disable iff (!arst_n)
    inRegEn && sprSel == SEL_ACC_HIGH |=> sprRdData == $past(acc_r[31:16]))
    else $error("accumulator high read wrong");
  a_acc_read_low: assert property (@(posedge clk) disable iff (!arst_n)
    inRegEn && sprSel == SEL_ACC_LOW |=> sprRdData == $past(acc_r[15:0]))
    else $error("accumulator low read wrong");
  a_read_strobe: assert property (@(posedge clk) disable iff (!arst_n)
    inRegEn |=> sprRdValid)
    else $error("read answer strobe missing");
  a_no_strobe: assert property (@(posedge clk) disable iff (!arst_n)
    !inRegEn |=> !sprRdValid)
    else $error("read answer strobe without request");
  a_read_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !inRegEn |=> $stable(sprRdData))
    else $error("read data changed without request");
  a_sp_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_STACK_POINTER |=> stackPointer_r == $past(sprWrData))
    else $error("stack pointer write lost");
  a_sp_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !stackPush && !stackPop && !(outRegEn && sprSel == SEL_STACK_POINTER) |=>
      $stable(stackPointer_r))
    else $error("stack pointer moved while idle");
  a_idle_addr: assert property (@(posedge clk) disable iff (!arst_n)
    !stackPop |-> stackAddr == stackPointer_r)
    else $error("stack address not pointer");
  a_discrete_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_DISCRETE_OUT |=> discreteOut == $past(sprWrData[7:0]))
    else $error("discrete write lost");
  a_tx_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_UART_TX |=> uartTxOut == $past(sprWrData))
    else $error("transmit buffer write lost");
  a_tx_unreadable: assert property (@(posedge clk) disable iff (!arst_n)
    inRegEn && sprSel == SEL_UART_TX |=> sprRdData == RST_ZERO)
    else $error("transmit buffer read back");
  a_rx_load: assert property (@(posedge clk) disable iff (!arst_n)
    uartRxLoad |=> uartRx_r == $past(uartRxIn))
    else $error("receive word not loaded");
  a_instr_load: assert property (@(posedge clk) disable iff (!arst_n)
    instrLoad |=> curInstr_r == $past(instrIn))
    else $error("instruction not latched");
  a_pending_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_PENDING_INT |=> pendingOut == $past(sprWrData))
    else $error("pending write lost");
  a_fault_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_FAULT_FLAGS |=> faultOut == $past(sprWrData))
    else $error("fault write lost");
  a_counter_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_INSTR_COUNTER |=> instrCount == $past(sprWrData))
    else $error("counter write lost");
  a_coarse_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_COARSE_TIMER |=> coarseTimerOut == $past(sprWrData))
    else $error("coarse timer write lost");
  a_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_INT_MASK |=> intMaskOut == $past(sprWrData))
    else $error("mask write lost");
  a_save_write: assert property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_INSTR_CNT_SAVE |=> instrCountSave_r[15:0] == $past(sprWrData))
    else $error("counter save write lost");

  c_pair_write: cover property (@(posedge clk) disable iff (!arst_n) wrPairEn);
  c_push_pop:   cover property (@(posedge clk) disable iff (!arst_n) stackPush ##1 stackPop);
  c_acc_read:   cover property (@(posedge clk) disable iff (!arst_n)
    inRegEn && sprSel == SEL_ACC_HIGH);
  c_sp_write_pop: cover property (@(posedge clk) disable iff (!arst_n)
    outRegEn && sprSel == SEL_STACK_POINTER && stackPop);
  c_pair_single:  cover property (@(posedge clk) disable iff (!arst_n)
    wrPairEn && wrEn);
endmodule : crf_core_register_file

// ---- test/tb_top.sv ----
// self-checking bench for the core register file
module tb_top
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk = 1'b0, arst_n = 1'b0;
  logic [4:0]  rdAddrA = 5'h00, rdAddrB = 5'h00, wrAddr = 5'h00;
  logic        wrEn = 1'b0, wrPairEn = 1'b0, stackPush = 1'b0, stackPop = 1'b0;
  logic        outRegEn = 1'b0, inRegEn = 1'b0, uartRxLoad = 1'b0, instrLoad = 1'b0;
  logic [3:0]  sprSel = 4'h0;
  logic [15:0] wrData = 16'h0000, sprWrData = 16'h0000, statusIn = 16'h0000;
  logic [15:0] uartRxIn = 16'h0000, instrIn = 16'h0000;
  logic [31:0] wrPairData = 32'h0, accData = 32'h0, rdPair;
  crf_acc_op_t accOp = CRF_ACC_NONE;
  logic [15:0] rdDataA, rdDataB, stackAddr, sprRdData, uartTxOut, instrCount, intMaskOut;
  logic [15:0] pendingOut, faultOut, fineTimerOut, coarseTimerOut, rv;
  logic [7:0]  discreteOut;
  logic        sprRdValid;
  int          numErrors = 0, totalChecks = 0;

  crf_core_register_file crf_core_register_file_i (
    .clk(clk), .arst_n(arst_n), .rdAddrA(rdAddrA), .rdDataA(rdDataA), .rdAddrB(rdAddrB),
    .rdDataB(rdDataB), .rdPairA(rdPair), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .wrPairEn(wrPairEn), .wrPairData(wrPairData), .accOp(accOp), .accData(accData),
    .stackPush(stackPush), .stackPop(stackPop), .stackAddr(stackAddr), .outRegEn(outRegEn),
    .inRegEn(inRegEn), .sprSel(sprSel), .sprWrData(sprWrData), .sprRdData(sprRdData),
    .sprRdValid(sprRdValid), .statusIn(statusIn), .uartRxIn(uartRxIn),
    .uartRxLoad(uartRxLoad), .instrIn(instrIn), .instrLoad(instrLoad), .uartTxOut(uartTxOut),
    .discreteOut(discreteOut), .instrCount(instrCount), .intMaskOut(intMaskOut),
    .pendingOut(pendingOut), .faultOut(faultOut), .fineTimerOut(fineTimerOut),
    .coarseTimerOut(coarseTimerOut));

  initial begin
    forever #10 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic sprWrite(input logic [3:0] s, input logic [15:0] d);
    @(posedge clk);
    outRegEn  <= 1'b1;
    sprSel    <= s;
    sprWrData <= d;
    @(posedge clk);
    outRegEn  <= 1'b0;
  endtask : sprWrite

  // answer strobe stands one cycle, so it is looked at in that cycle only
  task automatic sprRead(input logic [3:0] s, output logic [15:0] v);
    @(posedge clk);
    inRegEn <= 1'b1;
    sprSel  <= s;
    @(posedge clk);
    inRegEn <= 1'b0;
    @(negedge clk);
    check(sprRdValid, 1'b1, "read strobe");
    v = sprRdData;
  endtask : sprRead

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset_values;
    check(pendingOut, 16'h0000, "pending");
    check(faultOut, 16'h0000, "fault");
    check(instrCount, 16'h0000, "counter");
    check(fineTimerOut, 16'h0000, "fine");
    check(coarseTimerOut, 16'h0000, "coarse");
    check(discreteOut, 8'hff, "discrete");
    check(uartTxOut[7:0], 8'h00, "tx low");
    sprRead(SEL_UART_RX, rv);
    check(rv[7:0], 8'h00, "rx low");
    sprRead(SEL_CUR_INSTR, rv);
    check(rv, 16'h0000, "instruction");
    $display("test reset values done");
  endtask : test_reset_values

  // back-to-back writes, the last one at the first index past the file
  task automatic test_general;
    for (int i = 0; i <= 20; i++) begin
      @(posedge clk);
      wrEn   <= 1'b1;
      wrAddr <= 5'(i);
      wrData <= 16'ha500 + 16'(i);
    end
    @(posedge clk);
    wrEn <= 1'b0;
    for (int i = 0; i <= 20; i++) begin
      @(posedge clk);
      rdAddrA <= 5'(i);
      rdAddrB <= 5'(20 - i);
      @(negedge clk);
      check(rdDataA, (i < 20) ? 16'ha500 + 16'(i) : 16'h0000, "port a");
      check(rdDataB, (i > 0) ? 16'ha514 - 16'(i) : 16'h0000, "port b");
    end
    $display("test general registers done");
  endtask : test_general

  task automatic test_pair;
    @(posedge clk);
    wrPairEn   <= 1'b1;
    wrAddr     <= 5'h07;
    wrPairData <= 32'h1234abcd;
    @(posedge clk);
    wrPairEn <= 1'b0;
    rdAddrA  <= 5'h06;
    rdAddrB  <= 5'h07;
    @(negedge clk);
    check(rdDataA, 16'h1234, "pair high");
    check(rdDataB, 16'habcd, "pair low");
    check(rdPair, 32'h1234abcd, "pair");
    $display("test register pair done");
  endtask : test_pair

  task automatic test_accumulator;
    crf_acc_op_t ops[2] = '{CRF_ACC_MUL, CRF_ACC_DIV};
    logic [31:0] vals[2] = '{32'hdead0001, 32'h0000beef};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      accOp   <= ops[i];
      accData <= vals[i];
      @(posedge clk);
      accOp   <= CRF_ACC_NONE;
      accData <= 32'hffffffff;
      sprRead(SEL_ACC_HIGH, rv);
      check(rv, vals[i][31:16], "acc high");
      sprRead(SEL_ACC_LOW, rv);
      check(rv, vals[i][15:0], "acc low");
    end
    $display("test accumulator done");
  endtask : test_accumulator

  task automatic test_stack;
    sprWrite(SEL_STACK_POINTER, 16'h8010);
    sprRead(SEL_STACK_POINTER, rv);
    check(rv, 16'h8010, "sp load");
    @(posedge clk);
    stackPush <= 1'b1;
    @(negedge clk);
    check(stackAddr, 16'h8010, "push addr");
    @(posedge clk);
    stackPush <= 1'b0;
    stackPop  <= 1'b1;
    @(negedge clk);
    check(stackAddr, 16'h8010, "pop addr");
    @(posedge clk);
    stackPop <= 1'b0;
    sprWrite(SEL_STACK_POINTER, 16'h0000);
    @(posedge clk);
    stackPush <= 1'b1;
    @(posedge clk);
    stackPush <= 1'b0;
    sprRead(SEL_STACK_POINTER, rv);
    check(rv, 16'hffff, "push wrap");
    $display("test stack pointer done");
  endtask : test_stack

  task automatic test_special;
    logic [3:0]  sels[10] = '{SEL_INT_MASK, SEL_PENDING_INT, SEL_FAULT_FLAGS, SEL_DISCRETE_OUT,
      SEL_INSTR_COUNTER, SEL_FINE_TIMER, SEL_COARSE_TIMER, SEL_UART_TX, SEL_INSTR_CNT_SAVE, 4'hf};
    logic [15:0] vals[10] = '{16'h1111, 16'h2222, 16'h3333, 16'h44aa, 16'h5555, 16'h6666,
      16'h7777, 16'h0088, 16'h9abc, 16'hbbbb};
    @(posedge clk);
    statusIn   <= 16'h5a3c;
    uartRxLoad <= 1'b1;
    uartRxIn   <= 16'h0142;
    instrLoad  <= 1'b1;
    instrIn    <= 16'h7e81;
    @(posedge clk);
    uartRxLoad <= 1'b0;
    instrLoad  <= 1'b0;
    sprRead(SEL_SYSTEM_STATUS, rv);
    check(rv, 16'h5a3c, "status");
    sprRead(SEL_UART_RX, rv);
    check(rv, 16'h0142, "rx");
    sprRead(SEL_CUR_INSTR, rv);
    check(rv, 16'h7e81, "instruction");
    for (int i = 0; i < 10; i++) begin
      sprWrite(sels[i], vals[i]);
    end
    @(negedge clk);
    check({intMaskOut, pendingOut}, 32'h11112222, "mask pending");
    check({faultOut, instrCount}, 32'h33335555, "fault counter");
    check({fineTimerOut, coarseTimerOut}, 32'h66667777, "timers");
    check({uartTxOut, discreteOut}, 24'h0088aa, "tx discrete");
    // transmit buffer is write only and the spare selector holds nothing
    for (int i = 0; i < 10; i++) begin
      sprRead(sels[i], rv);
      check(rv, (i >= 7 && i != 8) ? 16'h0000 : vals[i], "readback");
    end
    $display("test special registers done");
  endtask : test_special

  // colliding requests: pair beats single, pointer write beats pop beats push
  task automatic test_priority;
    @(posedge clk);
    wrPairEn   <= 1'b1;
    wrEn       <= 1'b1;
    wrAddr     <= 5'h0a;
    wrData     <= 16'h0bad;
    wrPairData <= 32'hc0de5eed;
    @(posedge clk);
    wrPairEn <= 1'b0;
    wrEn     <= 1'b0;
    rdAddrA  <= 5'h0a;
    @(negedge clk);
    check(rdPair, 32'hc0de5eed, "pair over single");
    @(posedge clk);
    outRegEn  <= 1'b1;
    sprSel    <= SEL_STACK_POINTER;
    sprWrData <= 16'h4000;
    stackPop  <= 1'b1;
    stackPush <= 1'b1;
    @(posedge clk);
    outRegEn <= 1'b0;
    @(negedge clk);
    check(stackAddr, 16'h4001, "pop over push");
    @(posedge clk);
    stackPop  <= 1'b0;
    stackPush <= 1'b0;
    sprRead(SEL_STACK_POINTER, rv);
    check(rv, 16'h4001, "sp after pop");
    $display("test priority done");
  endtask : test_priority

  // ****************************************
  // sequence and watchdog
  // ****************************************
  // the tests need under two hundred cycles; the margin covers a stalled read
  initial begin
    repeat (3000) @(posedge clk);
    numErrors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    test_reset_values();
    test_general();
    test_pair();
    test_accumulator();
    test_stack();
    test_special();
    test_priority();
    report_and_stop();
  end
endmodule : tb_top
